/* hdl/ccsu_cmd.v */
// Serial command interpreter: firmware SRAM, configuration, control op-codes, results
`timescale 1ns/100ps
`default_nettype none
`include "ccsu_map.vh"
module ccsu_cmd #(
  parameter [31:0] SEQ_PERIOD = `CCSU_SEQ_PERIOD
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ssn,
  input  wire        sck,
  input  wire        mosi,
  output reg         miso_r,
  input  wire        fe_cap_done,
  input  wire [23:0] fe_time_bins,
  input  wire [23:0] fe_cap_ratio,
  input  wire        fe_res_done,
  input  wire [23:0] fe_temp_ratio,
  output wire        capacitance_conversion_run,
  output wire        resistance_conversion_run,
  output reg         fw_loaded_r
);
  reg  [7:0]  sram [0:4095];
  reg  [23:0] cfg  [0:63];
  reg         sck_d_r;
  reg  [5:0]  bits_r;
  reg  [31:0] sh_r;
  reg  [23:0] out_r;
  reg  [23:0] discharge_time_result;
  reg  [23:0] capacitance_ratio_result;
  reg  [23:0] temperature_ratio_result;
  reg  [23:0] front_end_run_control;
  reg         clr_r;
  reg         go_r;
  reg         por_r;
  wire        meas_active;
  wire [31:0] sh_nxt;
  wire        rise;
  wire        fall;
  wire [5:0]  bits_nxt;

  assign rise     = sck && !sck_d_r && !ssn;
  assign fall     = !sck && sck_d_r && !ssn;
  assign sh_nxt   = {sh_r[30:0], mosi};
  assign bits_nxt = bits_r + 6'h01;

  // ----------------------------------------------------------------
  // Read address decode
  // ----------------------------------------------------------------
  function [23:0] rd_word;
    input [5:0] a;
    begin
      case (a)
        `CCSU_ADDR_TIME:   rd_word = discharge_time_result;
        `CCSU_ADDR_CRATIO: rd_word = capacitance_ratio_result;
        `CCSU_ADDR_TRATIO: rd_word = temperature_ratio_result;
        `CCSU_ADDR_STATUS: rd_word = meas_active ?
                             (`CCSU_STATUS_RUN | (capacitance_conversion_run ?
                              `CCSU_STATUS_BUSY : `CCSU_ZERO24)) : `CCSU_ZERO24;
        `CCSU_ADDR_RUNCTL: rd_word = front_end_run_control;
        default:           rd_word = `CCSU_ZERO24;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Serial shifter and command decode
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      sck_d_r <= 1'b0;
      bits_r  <= 6'h00;
      sh_r    <= 32'h00000000;
      out_r   <= `CCSU_ZERO24;
      miso_r  <= 1'b0;
      go_r    <= 1'b0;
      clr_r   <= 1'b0;
      por_r   <= 1'b0;
    end else begin
      sck_d_r <= sck;
      go_r    <= 1'b0;
      clr_r   <= 1'b0;
      por_r   <= 1'b0;
      if (ssn) begin
        // Frame boundary; a partial frame is dropped without effect
        bits_r <= 6'h00;
      end else if (rise) begin
        sh_r   <= sh_nxt;
        bits_r <= bits_nxt;
        if (bits_nxt == `CCSU_BITS_CTRL) begin
          case (sh_nxt[7:6])
            `CCSU_KIND_CTRL: begin
              if (sh_nxt[7:0] == `CCSU_OP_PARTIAL)
                clr_r <= 1'b1;
              else if (sh_nxt[7:0] == `CCSU_OP_START)
                go_r <= 1'b1;
              else if (sh_nxt[7:0] == `CCSU_OP_POR) begin
                clr_r <= 1'b1;
                por_r <= 1'b1;
              end
            end
            `CCSU_KIND_RES_RD: out_r <= rd_word(sh_nxt[5:0]);
            default: out_r <= `CCSU_ZERO24;
          endcase
        end
        if (bits_nxt == `CCSU_BITS_RD_SRAM && sh_nxt[15:12] == `CCSU_NIB_SRAM_RD)
          out_r <= {sram[sh_nxt[11:0]], 16'h0000};
      end else if (fall) begin
        miso_r <= out_r[23];
        if (bits_r >= `CCSU_BITS_CTRL)
          out_r <= {out_r[22:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage: SRAM, configuration, run control
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rise && !ssn) begin
      if (bits_nxt == `CCSU_BITS_SRAM_WR && sh_nxt[23:20] == `CCSU_NIB_SRAM_WR)
        sram[sh_nxt[19:8]] <= sh_nxt[7:0];
      if (bits_nxt == `CCSU_BITS_FRAME && sh_nxt[31:30] == `CCSU_KIND_CFG_WR)
        cfg[sh_nxt[29:24]] <= sh_nxt[23:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n || por_r) begin
      front_end_run_control <= `CCSU_ZERO24;
      fw_loaded_r           <= 1'b0;
    end else if (rise && !ssn) begin
      // Run control is kept on a partial reset so configuration survives
      if (bits_nxt == `CCSU_BITS_FRAME && sh_nxt[31:30] == `CCSU_KIND_CFG_WR
          && sh_nxt[29:24] == `CCSU_ADDR_RUNCTL)
        front_end_run_control <= sh_nxt[23:0];
      if (bits_nxt == `CCSU_BITS_SRAM_WR && sh_nxt[23:20] == `CCSU_NIB_SRAM_WR)
        fw_loaded_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n || clr_r) begin
      discharge_time_result    <= `CCSU_ZERO24;
      capacitance_ratio_result <= `CCSU_ZERO24;
      temperature_ratio_result <= `CCSU_ZERO24;
    end else begin
      if (fe_cap_done && meas_active) begin
        discharge_time_result    <= fe_time_bins;
        capacitance_ratio_result <= fe_cap_ratio;
      end
      if (fe_res_done && meas_active && front_end_run_control[`CCSU_BIT_TEMP_EN])
        temperature_ratio_result <= fe_temp_ratio;
    end
  end

  ccsu_meas_seq #(
    .SEQ_PERIOD (SEQ_PERIOD)
  ) u_seq (
    .clk         (clk),
    .rst_n       (rst_n),
    .clr         (clr_r),
    .go          (go_r),
    .run         (front_end_run_control[`CCSU_BIT_RUN]),
    .temp_en     (front_end_run_control[`CCSU_BIT_TEMP_EN]),
    .cont        (front_end_run_control[`CCSU_BIT_CONT]),
    .div         (front_end_run_control[`CCSU_DIV_MSB:`CCSU_DIV_LSB]),
    .cap_done    (fe_cap_done),
    .cap_start_r (capacitance_conversion_run),
    .res_start_r (resistance_conversion_run),
    .active_r    (meas_active)
  );
endmodule
`default_nettype wire

/* hdl/ccsu_map.vh */
// Command codes, register addresses and field positions of the command interpreter
`ifndef CCSU_MAP_VH
`define CCSU_MAP_VH
`define CCSU_KIND_CFG_WR   2'b11
`define CCSU_KIND_RES_RD   2'b01
`define CCSU_KIND_CTRL     2'b10
`define CCSU_KIND_SRAM_RD  2'b00
`define CCSU_OP_POR        8'h88
`define CCSU_OP_PARTIAL    8'h8A
`define CCSU_OP_START      8'h8C
`define CCSU_NIB_SRAM_WR   4'h9
`define CCSU_NIB_SRAM_RD   4'h1
`define CCSU_ADDR_TIME     6'h00
`define CCSU_ADDR_CRATIO   6'h01
`define CCSU_ADDR_STATUS   6'h08
`define CCSU_ADDR_TRATIO   6'h0E
`define CCSU_ADDR_RUNCTL   6'h14
`define CCSU_BIT_RUN       0
`define CCSU_BIT_TEMP_EN   1
`define CCSU_BIT_CONT      2
`define CCSU_DIV_LSB       8
`define CCSU_DIV_MSB       15
`define CCSU_STATUS_RUN    24'h100000
`define CCSU_STATUS_BUSY   24'h800000
`define CCSU_ZERO24        24'h000000
`define CCSU_BITS_CTRL     6'h08
`define CCSU_BITS_RD_SRAM  6'h10
`define CCSU_BITS_SRAM_WR  6'h18
`define CCSU_BITS_FRAME    6'h20
`define CCSU_SEQ_PERIOD    32'h00FE502A
`endif

/* hdl/ccsu_meas_seq.v */
// Measurement trigger sequencer for capacitance and resistance runs
`timescale 1ns/100ps
`default_nettype none
`include "ccsu_map.vh"
module ccsu_meas_seq #(
  parameter [31:0] SEQ_PERIOD = `CCSU_SEQ_PERIOD
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clr,
  input  wire        go,
  input  wire        run,
  input  wire        temp_en,
  input  wire        cont,
  input  wire [7:0]  div,
  input  wire        cap_done,
  output reg         cap_start_r,
  output reg         res_start_r,
  output reg         active_r
);
  reg [31:0] tmr_r;
  reg [7:0]  cnt_r;

  // ----------------------------------------------------------------
  // Trigger generation
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n || clr) begin
      tmr_r       <= 32'h00000000;
      cnt_r       <= 8'h00;
      cap_start_r <= 1'b0;
      res_start_r <= 1'b0;
      active_r    <= 1'b0;
    end else begin
      cap_start_r <= 1'b0;
      res_start_r <= 1'b0;
      if (go && run) begin
        active_r    <= 1'b1;
        cap_start_r <= 1'b1;
        tmr_r       <= 32'h00000000;
      end else if (active_r && run) begin
        if (cont) begin
          if (cap_done)
            cap_start_r <= 1'b1;
        end else if (tmr_r >= SEQ_PERIOD - 32'h00000001) begin
          tmr_r       <= 32'h00000000;
          cap_start_r <= 1'b1;
        end else begin
          tmr_r <= tmr_r + 32'h00000001;
        end
        if (cap_done && temp_en) begin
          // Divider keeps slow temperature runs off the fast capacitance loop
          if (!cont || cnt_r >= div) begin
            cnt_r       <= 8'h00;
            res_start_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
      end else if (!run) begin
        active_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/ccsu_host.sv */
// Serial host model driving frames into the command interpreter
`timescale 1ns/100ps
`default_nettype none
module ccsu_host (
  input  wire logic clk,
  input  wire logic miso,
  output var logic  ssn,
  output var logic  sck,
  output var logic  mosi
);
  initial begin
    ssn = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // Each clock level lasts four cycles so the device detector always settles
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0;
    @(negedge clk) ssn = 1'b0;
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      mosi = tx[31-i];
      repeat (4) @(negedge clk);
      rx = {rx[30:0], miso};
      sck = 1'b1;
      repeat (4) @(negedge clk);
    end
    ssn = 1'b1;
    mosi = ~mosi;
    @(negedge clk) sck = 1'b0;
    repeat (3) @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* verif/ccsu_sva.sv */
// Port checker for the serial command interpreter
`timescale 1ns/100ps
`default_nettype none
module ccsu_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ssn,
  input wire logic sck,
  input wire logic miso_r,
  input wire logic fe_cap_done,
  input wire logic capacitance_conversion_run,
  input wire logic resistance_conversion_run,
  input wire logic fw_loaded_r
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_clears_runs: assert property (disable iff (1'b0) !rst_n |=> !capacitance_conversion_run
    && !resistance_conversion_run && !fw_loaded_r) else $error("outputs not cleared by reset");
  a_cap_single_pulse: assert property (capacitance_conversion_run |=> !capacitance_conversion_run)
    else $error("capacitance start longer than one cycle");
  a_res_single_pulse: assert property ($rose(resistance_conversion_run) |=> $fell(resistance_conversion_run))
    else $error("resistance start longer than one cycle");
  a_cap_run_spacing: assert property (capacitance_conversion_run |=> !capacitance_conversion_run [*3])
    else $error("capacitance starts too close");
  a_res_after_cap: assert property (resistance_conversion_run |-> $past(fe_cap_done)
    || $past(fe_cap_done, 2) || $past(fe_cap_done, 3)) else $error("resistance start without capacitance end");
  a_fw_set_frame: assert property ($rose(fw_loaded_r) |-> !$past(ssn))
    else $error("firmware flag set outside a frame");
  a_fw_clear_frame: assert property ($fell(fw_loaded_r) |-> !$past(ssn))
    else $error("firmware flag cleared outside a frame");
  a_miso_hold_high: assert property (!ssn && sck && $past(sck) && $past(sck, 2) |-> $stable(miso_r))
    else $error("serial output moved while clock high");
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the serial command interpreter
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, rst_n, ssn, sck, mosi, miso, cap_run, res_run, fw_loaded, fe_cap_done, fe_res_done;
  logic [2:0]  cd, rdl;
  logic [31:0] rx;
  int          cap_cnt, res_cnt, err_total, comparisons, cyc;
  ccsu_cmd #(.SEQ_PERIOD(32'h00000032)) uut (.clk(clk), .rst_n(rst_n), .ssn(ssn), .sck(sck), .mosi(mosi),
    .miso_r(miso), .fe_cap_done(fe_cap_done), .fe_time_bins(24'h011170), .fe_cap_ratio(24'h1FF2A0),
    .fe_res_done(fe_res_done), .fe_temp_ratio(24'h1AB3F0), .capacitance_conversion_run(cap_run),
    .resistance_conversion_run(res_run), .fw_loaded_r(fw_loaded));
  ccsu_host host (.clk(clk), .miso(miso), .ssn(ssn), .sck(sck), .mosi(mosi));
  // ----------------------------------------
  // Clock, front end and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (!rst_n) begin
      fe_cap_done <= 1'b0;
      fe_res_done <= 1'b0;
      cd <= 3'h0;
      rdl <= 3'h0;
    end else begin
      fe_cap_done <= (cd == 3'h1);
      fe_res_done <= (rdl == 3'h1);
      cd <= cap_run ? 3'h5 : (cd != 3'h0 ? cd - 3'h1 : 3'h0);
      rdl <= res_run ? 3'h5 : (rdl != 3'h0 ? rdl - 3'h1 : 3'h0);
      if (cap_run) cap_cnt <= cap_cnt + 1;
      if (res_run) res_cnt <= res_cnt + 1;
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end
  // ----------------------------------------
  // Helpers and scenarios
  // ----------------------------------------
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task op(input logic [7:0] b);
    host.xfer({b, 24'h000000}, 8, rx);
  endtask
  task wr(input logic [5:0] a, input logic [23:0] d);
    host.xfer({2'b11, a, d}, 32, rx);
  endtask
  task rd(input logic [5:0] a);
    host.xfer({2'b01, a, 24'h000000}, 32, rx);
  endtask
  task t_boot;
    op(8'h88);
    chk("fw_clear", {31'h0, fw_loaded}, 32'h0);
    host.xfer({4'h9, 12'hFFF, 8'hA5, 8'h00}, 24, rx);
    host.xfer({4'h9, 12'h000, 8'h5A, 8'h00}, 24, rx);
    chk("fw_set", {31'h0, fw_loaded}, 32'h1);
    host.xfer({4'h1, 12'hFFF, 16'h0000}, 24, rx);
    chk("sram_top", {24'h0, rx[7:0]}, 32'hA5);
    host.xfer({4'h1, 12'h000, 16'h0000}, 24, rx);
    chk("sram_low", {24'h0, rx[7:0]}, 32'h5A);
  endtask
  task t_config;
    for (int i = 0; i < 11; i++) wr(i[5:0], {i[7:0], 16'h00FF});
    wr(6'h14, 24'h000003);
    rd(6'h14);
    chk("runctl", {8'h0, rx[23:0]}, 32'h3);
    rd(6'h08);
    chk("status_idle", {8'h0, rx[23:0]}, 32'h0);
  endtask
  task t_seq;
    int c0, r0;
    op(8'h8A);
    op(8'h8C);
    repeat (50) @(negedge clk);
    rd(6'h08);
    chk("status_run", {8'h0, rx[23:0] & 24'h7FFFFF}, 32'h100000);
    rd(6'h00);
    chk("time_bins", {8'h0, rx[23:0]}, 32'h011170);
    rd(6'h01);
    chk("cap_ratio", {8'h0, rx[23:0]}, 32'h1FF2A0);
    rd(6'h0E);
    chk("temp_ratio", {8'h0, rx[23:0]}, 32'h1AB3F0);
    @(posedge cap_run);
    repeat (20) @(negedge clk);
    c0 = cap_cnt;
    r0 = res_cnt;
    repeat (150) @(negedge clk);
    chk("cap_runs", cap_cnt - c0, 32'h3);
    chk("res_runs", res_cnt - r0, 32'h3);
  endtask
  task t_partial;
    int c0, r0;
    op(8'h8A);
    op(8'h8F);
    host.xfer({2'b11, 6'h14, 24'h000000}, 16, rx);
    chk("fw_kept", {31'h0, fw_loaded}, 32'h1);
    rd(6'h14);
    chk("cfg_kept", {8'h0, rx[23:0]}, 32'h3);
    rd(6'h00);
    chk("res_cleared", {8'h0, rx[23:0]}, 32'h0);
    c0 = cap_cnt;
    repeat (100) @(negedge clk);
    chk("stopped", cap_cnt - c0, 32'h0);
    // Temperature off: capacitance runs go on, no resistance run may follow
    wr(6'h14, 24'h000001);
    c0 = cap_cnt;
    r0 = res_cnt;
    op(8'h8C);
    repeat (120) @(negedge clk);
    rd(6'h0E);
    chk("temp_off_ratio", {8'h0, rx[23:0]}, 32'h0);
    op(8'h8A);
    chk("temp_off_cap", {31'h0, cap_cnt > c0}, 32'h1);
    chk("temp_off_res", res_cnt - r0, 32'h0);
  endtask
  task t_cont;
    int c0, r0, c, r;
    wr(6'h14, 24'h000207);
    op(8'h8A);
    c0 = cap_cnt;
    r0 = res_cnt;
    op(8'h8C);
    repeat (200) @(negedge clk);
    op(8'h8A);
    repeat (20) @(negedge clk);
    c = cap_cnt - c0;
    r = res_cnt - r0;
    chk("res_divided", {31'h0, r * 3 <= c && r * 3 + 6 > c && r > 0}, 32'h1);
    op(8'h88);
    chk("fw_por", {31'h0, fw_loaded}, 32'h0);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_boot;
    t_config;
    t_seq;
    t_partial;
    t_cont;
    complete_run;
  end
endmodule
bind ccsu_cmd ccsu_sva chk_i (.clk(clk), .rst_n(rst_n), .ssn(ssn), .sck(sck), .miso_r(miso_r),
  .fe_cap_done(fe_cap_done), .capacitance_conversion_run(capacitance_conversion_run),
  .resistance_conversion_run(resistance_conversion_run), .fw_loaded_r(fw_loaded_r));
`default_nettype wire
